// ===== rtl/cfgd_attr_reg.sv
`timescale 1ns/1ps
module cfgd_attr_reg
    import cfgd_pkg::*;
#(
    parameter logic [31:0] RO_MASK  = ATTR_RO_MASK,
    parameter logic [31:0] W1C_MASK = ATTR_W1C_MASK,
    parameter logic [31:0] WO_MASK  = ATTR_WO_MASK,
    parameter logic [31:0] W1O_MASK = ATTR_W1O_MASK,
    parameter logic [31:0] RST_VAL  = ATTR_RST
) (
    input  wire logic        i_core_clk, // Core clock
    input  wire logic        i_reset,    // Async reset, high
    input  wire logic        i_wr,       // Write strobe
    input  wire logic [3:0]  i_be,       // Byte enables
    input  wire logic [31:0] i_wdata,    // Write data
    input  wire logic [31:0] i_hw_set,   // Hardware set events
    input  wire logic [31:0] i_ro_val,   // Live read-only values
    output logic      [31:0] o_value     // Read value
);
    logic [31:0] value_r;
    logic [31:0] value_nxt;
    logic [3:0]  lock_r;
    logic [31:0] wm;

    always_comb begin
        wm        = cfgd_be_mask(i_be) & {32{i_wr}};
        value_nxt = cfgd_merge(value_r, i_wdata, wm & ~(RO_MASK | W1C_MASK | WO_MASK | W1O_MASK));
        value_nxt = value_nxt & ~(wm & i_wdata & W1C_MASK);
        value_nxt = cfgd_merge(value_nxt, i_wdata, wm & WO_MASK & cfgd_be_mask(~lock_r));
        value_nxt = value_nxt | (wm & i_wdata & W1O_MASK);
        // Set wins over a clear in the same cycle
        value_nxt = value_nxt | (i_hw_set & W1C_MASK);
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            value_r <= RST_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            lock_r <= 4'h0;
        end else if (i_wr) begin
            lock_r <= lock_r | i_be;
        end
    end

    assign o_value = (value_r & ~RO_MASK) | (i_ro_val & RO_MASK);

    hw_set_wins_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_hw_set & W1C_MASK) != 32'h0 |=> (value_r & $past(i_hw_set) & W1C_MASK) == ($past(i_hw_set) & W1C_MASK))
        else $error("hardware-set bit did not set");
    wo_byte_lock_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        ((value_r ^ $past(value_r)) & WO_MASK & cfgd_be_mask($past(lock_r))) == 32'h0)
        else $error("locked write-once byte changed");
    w1c_clears_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_wr && i_hw_set == 32'h0 |=> (value_r & W1C_MASK & $past(wm) & $past(i_wdata)) == 32'h0)
        else $error("write one did not clear bit");
    w1o_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        ($past(value_r) & W1O_MASK & ~value_r) == 32'h0)
        else $error("write-one-only bit fell without reset");
    be_none_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_wr && i_be == 4'h0 && i_hw_set == 32'h0 |=> value_r == $past(value_r))
        else $error("write without byte enables changed register");

endmodule

// ===== rtl/cfgd_decode_attrs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Only type 0 configuration cycles reach registers
// - Device number from address bits 15:11
// - Function number from address bits 10:8
// - Dword offset from address bits 7:2
// - Bridges answer at base unit and base+1
// - Function 0 bridge, function 1 interrupt; link cap first
// - Unimplemented functions are forwarded, not claimed
// - Unimplemented offsets claimed; writes dropped, reads zero
// - Interrupt window base active only while visible
// - Hot-plug 4K window gated by per-bridge enable
// - Select at 0x90, data port at 0x94
// - Read-only bits ignore writes, read current value
// - Hardware-set bits set by events regardless
// - Write-once bytes lock until next reset
// - Write one clears; write zero does nothing
// - Write-one-only bits set, cleared only by reset
module cfgd_decode_attrs
    import cfgd_pkg::*;
#(
    parameter int HP_DWORDS  = 16,
    parameter int IRQ_DWORDS = 4
) (
    input  wire logic            i_core_clk,         // Core clock, 125 MHz
    input  wire logic            i_reset,            // Async reset, high
    input  wire logic [4:0]      i_base_unit_id,     // Programmed base unit id
    input  wire cfgd_req_s       i_cfg_req,          // Configuration cycle
    output cfgd_rsp_s            o_cfg_rsp,          // Configuration answer
    input  wire cfgd_req_s       i_mem_req,          // Memory cycle
    output cfgd_rsp_s            o_mem_rsp,          // Memory answer
    input  wire logic [1:0][7:0] i_hw_event,         // Status events per bridge
    input  wire logic [1:0][3:0] i_ro_status,        // Live status per bridge
    output logic      [1:0]      o_hp_access_en,     // Hot-plug enables
    output logic      [1:0]      o_irq_base_visible  // Interrupt base visible
);
    localparam int NB     = 2;
    localparam int HPI_W  = $clog2(HP_DWORDS);
    localparam int IRQI_W = $clog2(IRQ_DWORDS);
    localparam int DW_W   = WIN_LSB - OFF_LSB;

    logic [1:0][31:0]       hp_base_r;
    logic [1:0][31:0]       irq_base_r;
    logic [1:0][HPI_W-1:0]  hp_sel_r;
    logic [1:0]             irq_vis_r;
    logic [1:0]             hp_en_r;
    logic [31:0]            hp_mem_r  [NB][HP_DWORDS];
    logic [31:0]            irq_mem_r [NB][IRQ_DWORDS];
    logic [1:0][31:0]       attr_val;
    cfgd_rsp_s              cfg_rsp_r;
    cfgd_rsp_s              mem_rsp_r;

    logic [4:0]             c_dev;
    logic [2:0]             c_fn;
    logic [7:0]             c_off;
    logic                   c_hit_a;
    logic                   c_hit_b;
    logic                   c_br;
    logic                   c_claim;
    logic                   c_fwd;
    logic                   c_wr_f0;
    logic                   c_wr_f1;
    logic                   c_known;
    logic [31:0]            c_wmask;
    logic [31:0]            c_rdata;
    logic                   c_port_wr;

    logic                   m_claim;
    logic                   m_is_irq;
    logic                   m_br;
    logic [DW_W-1:0]        m_dw;
    logic                   m_hp_ok;
    logic                   m_irq_ok;
    logic [31:0]            m_rdata;
    logic                   m_hp_wr;
    logic                   m_irq_wr;

    logic                   p_wr_r;
    logic                   p_br_r;
    logic [HPI_W-1:0]       p_sel_r;
    logic [31:0]            p_data_r;

    always_comb begin
        c_dev   = i_cfg_req.addr[DEV_MSB:DEV_LSB];
        c_fn    = i_cfg_req.addr[FN_MSB:FN_LSB];
        c_off   = {i_cfg_req.addr[OFF_MSB:OFF_LSB], 2'b00};
        c_hit_a = (c_dev == i_base_unit_id);
        c_hit_b = (c_dev == 5'(i_base_unit_id + UNIT_STEP));
        c_br    = c_hit_b & ~c_hit_a;
        // Only functions 0 and 1 exist; anything else goes through the tunnel
        c_claim = i_cfg_req.valid & i_cfg_req.type0 & (c_hit_a | c_hit_b)
                  & (c_fn == FN_BRIDGE || c_fn == FN_IRQ);
        c_fwd   = i_cfg_req.valid & ~c_claim;
        c_wr_f0 = c_claim & i_cfg_req.write & (c_fn == FN_BRIDGE);
        c_wr_f1 = c_claim & i_cfg_req.write & (c_fn == FN_IRQ);
        c_wmask = cfgd_be_mask(i_cfg_req.be);
        c_port_wr = c_wr_f0 & (c_off == REG_HP_PORT) & hp_en_r[c_br];
    end

    // Read mux; locations not listed read as zero
    always_comb begin
        c_rdata = 32'h0;
        c_known = 1'b1;
        case (c_fn)
            FN_BRIDGE: begin
                case (c_off)
                    REG_WIN_BASE: c_rdata = hp_base_r[c_br];
                    REG_HP_SEL:   c_rdata[HPI_W-1:0] = hp_sel_r[c_br];
                    REG_HP_PORT: begin
                        if (hp_en_r[c_br]) begin
                            c_rdata = hp_mem_r[c_br][hp_sel_r[c_br]];
                        end
                    end
                    REG_ATTR:     c_rdata = attr_val[c_br];
                    REG_HP_EN: begin
                        c_known = ~c_br;
                        if (!c_br) begin
                            c_rdata[HP_EN_FIRST_BIT]  = hp_en_r[0];
                            c_rdata[HP_EN_SECOND_BIT] = hp_en_r[1];
                        end
                    end
                    REG_LINK_CAP: begin
                        c_known = ~c_br;
                        if (!c_br) begin
                            c_rdata = LINK_CAP_HDR;
                        end
                    end
                    default:      c_known = 1'b0;
                endcase
            end
            FN_IRQ: begin
                case (c_off)
                    REG_WIN_BASE: begin
                        if (irq_vis_r[c_br]) begin
                            c_rdata = irq_base_r[c_br];
                        end
                    end
                    REG_IRQ_VIS:  c_rdata[IRQ_VIS_BIT] = irq_vis_r[c_br];
                    default:      c_known = 1'b0;
                endcase
            end
            default: c_known = 1'b0;
        endcase
    end

    // Only address bits above the 4K boundary are kept
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            hp_base_r <= '0;
        end else if (c_wr_f0 && c_off == REG_WIN_BASE) begin
            hp_base_r[c_br] <= cfgd_merge(hp_base_r[c_br], i_cfg_req.wdata, c_wmask) & WIN_MASK;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_base_r <= '0;
        end else if (c_wr_f1 && c_off == REG_WIN_BASE && irq_vis_r[c_br]) begin
            irq_base_r[c_br] <= cfgd_merge(irq_base_r[c_br], i_cfg_req.wdata, c_wmask) & WIN_MASK;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_vis_r <= 2'h0;
        end else if (c_wr_f1 && c_off == REG_IRQ_VIS && i_cfg_req.be[0]) begin
            irq_vis_r[c_br] <= i_cfg_req.wdata[IRQ_VIS_BIT];
        end
    end

    // Enables for both bridges live in the first device only
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            hp_en_r <= 2'h0;
        end else if (c_wr_f0 && !c_br && c_off == REG_HP_EN && i_cfg_req.be[0]) begin
            hp_en_r <= {i_cfg_req.wdata[HP_EN_SECOND_BIT], i_cfg_req.wdata[HP_EN_FIRST_BIT]};
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            hp_sel_r <= '0;
        end else if (c_wr_f0 && c_off == REG_HP_SEL) begin
            hp_sel_r[c_br] <= HPI_W'(cfgd_merge(32'(hp_sel_r[c_br]), i_cfg_req.wdata, c_wmask));
        end
    end

    // Memory side: hot-plug windows first, then interrupt windows, bridge 0 before 1
    always_comb begin
        m_claim  = 1'b0;
        m_is_irq = 1'b0;
        m_br     = 1'b0;
        m_dw     = i_mem_req.addr[WIN_LSB-1:OFF_LSB];
        for (int b = NB - 1; b >= 0; b--) begin
            if (i_mem_req.valid && irq_vis_r[b]
                && i_mem_req.addr[31:WIN_LSB] == irq_base_r[b][31:WIN_LSB]) begin
                m_claim  = 1'b1;
                m_is_irq = 1'b1;
                m_br     = 1'(b);
            end
        end
        for (int b = NB - 1; b >= 0; b--) begin
            if (i_mem_req.valid && hp_en_r[b]
                && i_mem_req.addr[31:WIN_LSB] == hp_base_r[b][31:WIN_LSB]) begin
                m_claim  = 1'b1;
                m_is_irq = 1'b0;
                m_br     = 1'(b);
            end
        end
        m_hp_ok  = m_claim & ~m_is_irq & (m_dw < DW_W'(HP_DWORDS));
        m_irq_ok = m_claim & m_is_irq & (m_dw < DW_W'(IRQ_DWORDS));
        m_rdata  = 32'h0;
        if (m_hp_ok) begin
            m_rdata = hp_mem_r[m_br][m_dw[HPI_W-1:0]];
        end else if (m_irq_ok) begin
            m_rdata = irq_mem_r[m_br][m_dw[IRQI_W-1:0]];
        end
        // A configuration port write wins over a same-cycle memory write
        m_hp_wr  = m_hp_ok & i_mem_req.write & ~c_port_wr;
        m_irq_wr = m_irq_ok & i_mem_req.write;
    end

    always_ff @(posedge i_core_clk) begin
        if (c_port_wr) begin
            hp_mem_r[c_br][hp_sel_r[c_br]] <= cfgd_merge(hp_mem_r[c_br][hp_sel_r[c_br]],
                                                         i_cfg_req.wdata, c_wmask);
        end
        if (m_hp_wr) begin
            hp_mem_r[m_br][m_dw[HPI_W-1:0]] <= cfgd_merge(hp_mem_r[m_br][m_dw[HPI_W-1:0]],
                                                          i_mem_req.wdata, cfgd_be_mask(i_mem_req.be));
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (m_irq_wr) begin
            irq_mem_r[m_br][m_dw[IRQI_W-1:0]] <= cfgd_merge(irq_mem_r[m_br][m_dw[IRQI_W-1:0]],
                                                            i_mem_req.wdata, cfgd_be_mask(i_mem_req.be));
        end
    end

    for (genvar b = 0; b < NB; b++) begin : g_attr
        cfgd_attr_reg u_attr (
            .i_core_clk (i_core_clk),
            .i_reset    (i_reset),
            .i_wr       (c_wr_f0 && c_off == REG_ATTR && c_br == 1'(b)),
            .i_be       (i_cfg_req.be),
            .i_wdata    (i_cfg_req.wdata),
            .i_hw_set   ({16'h0, i_hw_event[b], 8'h0}),
            .i_ro_val   ({28'h0, i_ro_status[b]}),
            .o_value    (attr_val[b])
        );
    end

    // Reads answer with the value before any write in the same cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_rsp_r <= '0;
        end else begin
            cfg_rsp_r.done  <= i_cfg_req.valid;
            cfg_rsp_r.claim <= c_claim;
            cfg_rsp_r.fwd   <= c_fwd;
            cfg_rsp_r.rdata <= (c_claim && !i_cfg_req.write) ? c_rdata : 32'h0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            mem_rsp_r <= '0;
        end else begin
            mem_rsp_r.done  <= i_mem_req.valid;
            mem_rsp_r.claim <= m_claim;
            mem_rsp_r.fwd   <= i_mem_req.valid & ~m_claim;
            mem_rsp_r.rdata <= (m_claim && !i_mem_req.write) ? m_rdata : 32'h0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            p_wr_r   <= 1'b0;
            p_br_r   <= 1'b0;
            p_sel_r  <= '0;
            p_data_r <= 32'h0;
        end else begin
            p_wr_r   <= c_port_wr && i_cfg_req.be == 4'hF;
            p_br_r   <= c_br;
            p_sel_r  <= hp_sel_r[c_br];
            p_data_r <= i_cfg_req.wdata;
        end
    end

    assign o_cfg_rsp          = cfg_rsp_r;
    assign o_mem_rsp          = mem_rsp_r;
    assign o_hp_access_en     = hp_en_r;
    assign o_irq_base_visible = irq_vis_r;

    non_type0_fwd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_cfg_req.valid && !i_cfg_req.type0 |=> o_cfg_rsp.fwd && !o_cfg_rsp.claim)
        else $error("non type 0 cycle was claimed");
    unit_id_claim_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_cfg_req.valid && i_cfg_req.type0 && c_fn == FN_BRIDGE
        && (c_dev == i_base_unit_id || c_dev == 5'(i_base_unit_id + UNIT_STEP)) |=> o_cfg_rsp.claim)
        else $error("access at own unit id not claimed");
    bad_fn_fwd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_cfg_req.valid && c_fn != FN_BRIDGE && c_fn != FN_IRQ |=> o_cfg_rsp.fwd && !o_cfg_rsp.claim)
        else $error("unimplemented function was claimed");
    unimpl_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_claim && !i_cfg_req.write && !c_known |=> o_cfg_rsp.claim && o_cfg_rsp.rdata == 32'h0)
        else $error("unimplemented location read nonzero");
    irq_base_hidden_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_claim && !i_cfg_req.write && c_fn == FN_IRQ && c_off == REG_WIN_BASE && !irq_vis_r[c_br]
        |=> o_cfg_rsp.rdata == 32'h0)
        else $error("hidden interrupt base was readable");
    hp_gate_mem_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_mem_req.valid && hp_en_r == 2'h0 && irq_vis_r == 2'h0 |=> !o_mem_rsp.claim)
        else $error("memory claimed with all windows closed");
    hp_port_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        p_wr_r |-> hp_mem_r[p_br_r][p_sel_r] == p_data_r)
        else $error("data port write not stored at selected dword");
    link_cap_first_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_claim && !i_cfg_req.write && c_hit_a && c_fn == FN_BRIDGE && c_off == REG_LINK_CAP
        |=> o_cfg_rsp.rdata == LINK_CAP_HDR)
        else $error("link capability header wrong");
    cfg_claim_fwd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_cfg_req.valid |=> o_cfg_rsp.done && (o_cfg_rsp.claim != o_cfg_rsp.fwd))
        else $error("config answer not exactly claim or forward");
    mem_claim_fwd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_mem_req.valid |=> o_mem_rsp.done && (o_mem_rsp.claim != o_mem_rsp.fwd))
        else $error("memory answer not exactly claim or forward");
    unimpl_wr_drop_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_claim && i_cfg_req.write && !c_known
        |=> hp_base_r == $past(hp_base_r) && hp_sel_r == $past(hp_sel_r) && hp_en_r == $past(hp_en_r)
            && irq_vis_r == $past(irq_vis_r) && irq_base_r == $past(irq_base_r))
        else $error("unimplemented location write changed state");
    irq_base_lock_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_wr_f1 && c_off == REG_WIN_BASE && !irq_vis_r[c_br]
        |=> irq_base_r == $past(irq_base_r))
        else $error("hidden interrupt base was written");
    hp_port_gate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_claim && !i_cfg_req.write && c_fn == FN_BRIDGE && c_off == REG_HP_PORT && !hp_en_r[c_br]
        |=> o_cfg_rsp.rdata == 32'h0)
        else $error("gated hot-plug port was readable");
    en_first_only_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        c_wr_f0 && c_br && c_off == REG_HP_EN
        |=> hp_en_r == $past(hp_en_r))
        else $error("second device changed hot-plug enables");

endmodule

// ===== rtl/cfgd_pkg.sv
package cfgd_pkg;

    // Configuration address fields
    localparam int DEV_MSB = 15;
    localparam int DEV_LSB = 11;
    localparam int FN_MSB  = 10;
    localparam int FN_LSB  = 8;
    localparam int OFF_MSB = 7;
    localparam int OFF_LSB = 2;

    localparam logic [2:0] FN_BRIDGE = 3'h0;
    localparam logic [2:0] FN_IRQ    = 3'h1;
    localparam logic [4:0] UNIT_STEP = 5'h01;

    // Byte offsets inside a function
    localparam logic [7:0] REG_WIN_BASE = 8'h10;
    localparam logic [7:0] REG_IRQ_VIS  = 8'h44;
    localparam logic [7:0] REG_HP_EN    = 8'h48;
    localparam logic [7:0] REG_ATTR     = 8'h60;
    localparam logic [7:0] REG_HP_SEL   = 8'h90;
    localparam logic [7:0] REG_HP_PORT  = 8'h94;
    localparam logic [7:0] REG_LINK_CAP = 8'hC0;

    // Field positions
    localparam int IRQ_VIS_BIT      = 0;
    localparam int HP_EN_FIRST_BIT  = 0;
    localparam int HP_EN_SECOND_BIT = 1;

    // 4K memory windows
    localparam int          WIN_LSB  = 12;
    localparam logic [31:0] WIN_MASK = 32'hFFFF_F000;

    // Capability header of the link block; the value is arbitrary
    localparam logic [31:0] LINK_CAP_HDR = 32'h0000_0008;

    // Attribute layout of the per-bridge attribute register
    localparam logic [31:0] ATTR_RO_MASK  = 32'h0000_000F;
    localparam logic [31:0] ATTR_W1C_MASK = 32'h0000_FF00;
    localparam logic [31:0] ATTR_WO_MASK  = 32'h00FF_0000;
    localparam logic [31:0] ATTR_W1O_MASK = 32'hFF00_0000;
    localparam logic [31:0] ATTR_RST      = 32'h0000_0000;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        type0;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfgd_req_s;

    typedef struct packed {
        logic        done;
        logic        claim;
        logic        fwd;
        logic [31:0] rdata;
    } cfgd_rsp_s;

    function automatic logic [31:0] cfgd_be_mask(input logic [3:0] be);
        cfgd_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] cfgd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [31:0] mask);
        cfgd_merge = (new_v & mask) | (old_v & ~mask);
    endfunction

endpackage

// ===== tb/cfgd_decode_attrs_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cfgd_decode_attrs_tb_top;
    import cfgd_pkg::*;
    logic            clk = 1'b0;
    logic            i_reset = 1'b1;
    logic [1:0][7:0] ev = '0;
    logic [1:0][3:0] ro = {4'h5, 4'hA};
    logic [1:0]      hpen;
    logic [1:0]      vis;
    cfgd_req_s       creq, mreq;
    cfgd_rsp_s       crsp, mrsp, rs;
    int              n_mismatch = 0;
    int              checked = 0;
    localparam logic [4:0] DA = 5'h07;
    localparam logic [4:0] DB = 5'h08;
    logic [4:0]      uid = DA;

    initial forever #4 clk = ~clk;

    cfgd_decode_attrs dut_u (.i_core_clk(clk), .i_reset(i_reset), .i_base_unit_id(uid), .i_cfg_req(creq),
        .o_cfg_rsp(crsp), .i_mem_req(mreq), .o_mem_rsp(mrsp), .i_hw_event(ev), .i_ro_status(ro),
        .o_hp_access_en(hpen), .o_irq_base_visible(vis));
    cfgd_host_model host_u (.i_core_clk(clk), .i_cfg_rsp(crsp), .i_mem_rsp(mrsp), .o_cfg_req(creq),
        .o_mem_req(mreq));

    function automatic logic [31:0] ca(input logic [4:0] d, input logic [2:0] f, input logic [7:0] o);
        ca = {16'h0000, d, f, o};
    endfunction
    task automatic acc(input logic m, input logic w, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        host_u.xfer(m, w, 1'b1, a, be, wd, rs);
    endtask
    task automatic do_reset();
        @(posedge clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge clk);
        i_reset <= 1'b0;
    endtask

    task automatic t_decode();
        acc(0, 1, ca(DA, 0, 8'h10), 4'hF, 32'h1234_5678);
        `CHK({rs.done, rs.claim}, 2'b11)
        // The answer stands one cycle only
        repeat (2) @(negedge clk);
        `CHK({crsp.done, crsp.claim, crsp.fwd, crsp.rdata}, 35'h0)
        acc(0, 0, ca(DA, 0, 8'h10), 4'hF, 0);
        `CHK(rs.rdata, 32'h1234_5000)
        host_u.xfer(0, 0, 1'b0, ca(DA, 0, 8'h10), 4'hF, 0, rs);
        `CHK({rs.claim, rs.fwd}, 2'b01)
        acc(0, 0, ca(DB, 1, 8'h00), 4'hF, 0);
        `CHK({rs.claim, rs.fwd}, 2'b10)
        acc(0, 0, ca(DA, 2, 8'h10), 4'hF, 0);
        `CHK({rs.claim, rs.fwd}, 2'b01)
        acc(0, 0, ca(DA + 5'h02, 0, 8'h10), 4'hF, 0);
        `CHK({rs.claim, rs.fwd}, 2'b01)
        acc(0, 1, ca(DA, 0, 8'h20), 4'hF, 32'hFFFF_FFFF);
        acc(0, 0, ca(DA, 0, 8'h20), 4'hF, 0);
        `CHK({rs.claim, rs.rdata}, {1'b1, 32'h0})
        acc(0, 0, ca(DA, 0, 8'h13), 4'hF, 0);
        `CHK(rs.rdata, 32'h1234_5000)
        acc(0, 0, ca(DA, 0, 8'hC0), 4'hF, 0);
        `CHK(rs.rdata, LINK_CAP_HDR)
        acc(0, 0, ca(DB, 0, 8'hC0), 4'hF, 0);
        `CHK({rs.claim, rs.rdata}, {1'b1, 32'h0})
        // Second device wraps to unit 0 when the base is the top id
        @(posedge clk) uid <= 5'h1F;
        acc(0, 0, ca(5'h00, 0, 8'h10), 4'hF, 0);
        `CHK({rs.claim, rs.fwd}, 2'b10)
        @(posedge clk) uid <= DA;
    endtask

    task automatic t_attr();
        acc(0, 1, ca(DA, 0, 8'h60), 4'h1, 32'hFFFF_FFFF);
        acc(0, 0, ca(DA, 0, 8'h60), 4'hF, 0);
        `CHK(rs.rdata, 32'h0000_00FA)
        @(posedge clk) ev[0] <= 8'h81;
        @(posedge clk) ev[0] <= 8'h00;
        acc(0, 1, ca(DA, 0, 8'h60), 4'h2, 32'h0000_0100);
        acc(0, 0, ca(DA, 0, 8'h60), 4'hF, 0);
        `CHK(rs.rdata, 32'h0000_80FA)
        acc(0, 1, ca(DA, 0, 8'h60), 4'hC, 32'h0C3C_0000);
        acc(0, 1, ca(DA, 0, 8'h60), 4'hC, 32'hF0FF_0000);
        acc(0, 0, ca(DA, 0, 8'h60), 4'hF, 0);
        `CHK(rs.rdata, 32'hFC3C_80FA)
        acc(0, 1, ca(DA, 0, 8'h60), 4'h0, 32'hFFFF_FFFF);
        acc(0, 0, ca(DA, 0, 8'h60), 4'hF, 0);
        `CHK(rs.rdata, 32'hFC3C_80FA)
        acc(0, 1, ca(DA, 0, 8'h48), 4'h1, 32'h0000_0003);
        `CHK(hpen, 2'b11)
        do_reset();
        `CHK(hpen, 2'b00)
        acc(0, 1, ca(DA, 0, 8'h60), 4'h4, 32'h0011_0000);
        acc(0, 0, ca(DA, 0, 8'h60), 4'hF, 0);
        `CHK(rs.rdata, 32'h0011_000A)
    endtask

    task automatic t_windows();
        acc(0, 1, ca(DA, 0, 8'h10), 4'hF, 32'h1000_0000);
        acc(1, 1, 32'h1000_0008, 4'hF, 32'hAAAA_5555);
        `CHK({rs.claim, rs.fwd}, 2'b01)
        acc(0, 0, ca(DA, 0, 8'h94), 4'hF, 0);
        `CHK({rs.claim, rs.rdata}, {1'b1, 32'h0})
        acc(0, 1, ca(DA, 0, 8'h48), 4'h1, 32'h0000_0001);
        `CHK(hpen, 2'b01)
        acc(0, 1, ca(DB, 0, 8'h48), 4'h1, 32'h0000_0003);
        `CHK(hpen, 2'b01)
        acc(1, 1, 32'h1000_0008, 4'hF, 32'h1357_9BDF);
        acc(0, 1, ca(DA, 0, 8'h90), 4'hF, 32'h0000_0002);
        acc(0, 0, ca(DA, 0, 8'h94), 4'hF, 0);
        `CHK(rs.rdata, 32'h1357_9BDF)
        acc(0, 1, ca(DA, 0, 8'h94), 4'h3, 32'hFFFF_0246);
        acc(1, 0, 32'h1000_0008, 4'hF, 0);
        `CHK({rs.claim, rs.rdata}, {1'b1, 32'h1357_0246})
        acc(0, 1, ca(DA, 0, 8'h94), 4'hF, 32'h2468_ACE0);
        acc(1, 0, 32'h1000_0008, 4'hF, 0);
        `CHK({rs.done, rs.claim, rs.rdata}, {2'b11, 32'h2468_ACE0})
        acc(0, 1, ca(DA, 1, 8'h10), 4'hF, 32'h2000_0000);
        acc(0, 0, ca(DA, 1, 8'h10), 4'hF, 0);
        `CHK(rs.rdata, 32'h0)
        acc(0, 1, ca(DA, 1, 8'h44), 4'h1, 32'h0000_0001);
        acc(0, 1, ca(DA, 1, 8'h10), 4'hF, 32'h2000_0000);
        acc(1, 0, 32'h2000_0FFC, 4'hF, 0);
        `CHK({vis, rs.claim}, 3'b011)
        acc(1, 0, 32'h2000_1000, 4'hF, 0);
        `CHK(rs.fwd, 1'b1)
    endtask

    task automatic stop_test();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        i_reset <= 1'b0;
        t_decode();
        t_attr();
        t_windows();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule

// ===== tb/cfgd_host_model.sv
`timescale 1ns/1ps
module cfgd_host_model
    import cfgd_pkg::*;
(
    input  wire logic      i_core_clk, // Core clock
    input  wire cfgd_rsp_s i_cfg_rsp,  // Config answer
    input  wire cfgd_rsp_s i_mem_rsp,  // Memory answer
    output cfgd_req_s      o_cfg_req,  // Config cycle
    output cfgd_req_s      o_mem_req   // Memory cycle
);
    initial begin
        o_cfg_req = '0;
        o_mem_req = '0;
    end
    // Released lines show inverted values so a stale sample cannot pass
    task automatic xfer(input logic m, input logic w, input logic t0, input logic [31:0] a,
                        input logic [3:0] be, input logic [31:0] wd, output cfgd_rsp_s rsp);
        cfgd_req_s r;
        r = '{valid: 1'b1, write: w, type0: t0, addr: a, be: be, wdata: wd};
        @(posedge i_core_clk);
        if (m) o_mem_req <= r;
        else o_cfg_req <= r;
        @(posedge i_core_clk);
        r = ~r;
        r.valid = 1'b0;
        if (m) o_mem_req <= r;
        else o_cfg_req <= r;
        #1;
        rsp = m ? i_mem_rsp : i_cfg_rsp;
    endtask
endmodule
